// file: hw/btd_decoder.sv
// Purpose: Split a fetched bundle into template and slots, type them
// Assumes: Fetch presents little-endian 16-byte aligned bundles
// Notes:   One cycle from accepted bundle to registered result
// How it works
// [RULE1] Bundle is three 41-bit slots, 5-bit template
// [RULE2] Template 4:0, slots 45:5, 86:46, 127:87
// [RULE3] Bit zero is the least-significant bit
// [RULE4] Bundles sit on 16-byte aligned addresses
// [RULE5] Fetch bytes always read little-endian
// [RULE6] Six instruction types routed to unit kinds
// [RULE7] Template selects each slot's unit type
// [RULE8] Eight template values are reserved, unmapped
// [RULE9] Template 00 no stop; 03 two stops
// [RULE10] Stops passed on as dependency boundaries
// [RULE11] Long template X slot accepts break, no-op
// [RULE12] Extended op spans two adjacent slots
// [RULE13] Long branch/call on branch, else integer
// [RULE14] Slot 0 first, bundles by rising address
// [RULE15] Odd template adds stop; 0A, 0B special
// [RULE16] Reserved template raises illegal, issues nothing
`timescale 1ns/1ns
module btd_decoder
(
    // Clock and reset
    input  wire logic                               i_clk_sys,
    input  wire logic                               i_reset,
    // Fetch side
    input  wire logic                               i_fetch_valid,
    input  wire logic [btd_pkg::ADDR_W-1:0]         i_fetch_addr,
    input  wire logic [btd_pkg::BUNDLE_W-1:0]       i_fetch_bundle,
    output logic                                    o_fetch_ready,
    // Issue side
    input  wire logic                               i_issue_ready,
    output logic                                    o_issue_valid,
    output btd_pkg::btd_decoded_t                   o_issue,
    // Exception side
    output logic                                    o_illegal_op
);
    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    logic [btd_pkg::TMPL_W-1:0]  tmpl;
    logic [btd_pkg::SLOT_W-1:0]  slot_bits [btd_pkg::NUM_SLOTS];
    btd_pkg::btd_unit_t          unit      [btd_pkg::NUM_SLOTS];
    btd_pkg::btd_exec_t          exec_sel  [btd_pkg::NUM_SLOTS];
    logic [btd_pkg::NUM_SLOTS-1:0] stop;
    logic                        reserved;
    logic                        long_pair;
    logic                        misaligned;

    // Bundle is taken as a little-endian 128-bit word, bit 0 = LSB
    assign tmpl         = i_fetch_bundle[btd_pkg::TMPL_LSB +: btd_pkg::TMPL_W];  // [RULE2] [RULE3] [RULE5]
    assign slot_bits[0] = i_fetch_bundle[btd_pkg::SLOT0_LSB +: btd_pkg::SLOT_W]; // [RULE1] [RULE2]
    assign slot_bits[1] = i_fetch_bundle[btd_pkg::SLOT1_LSB +: btd_pkg::SLOT_W]; // [RULE2]
    assign slot_bits[2] = i_fetch_bundle[btd_pkg::SLOT2_LSB +: btd_pkg::SLOT_W]; // [RULE2]

    // Fetch should never offer an offset inside a bundle
    assign misaligned = |i_fetch_addr[btd_pkg::ALIGN_BITS-1:0];  // [RULE4]

    // ------------------------------------------------------------
    // Template table
    // ------------------------------------------------------------
    always_comb
    begin
        unit[0]  = btd_pkg::BTD_UNIT_NONE;
        unit[1]  = btd_pkg::BTD_UNIT_NONE;
        unit[2]  = btd_pkg::BTD_UNIT_NONE;
        reserved = 1'b0;
        // Odd member of each defined pair closes with a stop after slot 2
        stop     = {tmpl[0], 2'b00};  // [RULE15]
        case (tmpl[btd_pkg::TMPL_W-1:1])  // [RULE7]
            4'h0:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_I;
                unit[2] = btd_pkg::BTD_UNIT_I;
            end
            4'h1:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_I;
                unit[2] = btd_pkg::BTD_UNIT_I;
                stop[1] = 1'b1;  // [RULE9]
            end
            4'h2:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_L;  // [RULE12]
                unit[2] = btd_pkg::BTD_UNIT_X;  // [RULE11]
            end
            4'h4:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_M;
                unit[2] = btd_pkg::BTD_UNIT_I;
            end
            4'h5:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_M;
                unit[2] = btd_pkg::BTD_UNIT_I;
                stop[0] = 1'b1;  // [RULE15]
            end
            4'h6:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_F;
                unit[2] = btd_pkg::BTD_UNIT_I;
            end
            4'h7:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_M;
                unit[2] = btd_pkg::BTD_UNIT_F;
            end
            4'h8:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_I;
                unit[2] = btd_pkg::BTD_UNIT_B;
            end
            4'h9:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_B;
                unit[2] = btd_pkg::BTD_UNIT_B;
            end
            4'hB:
            begin
                unit[0] = btd_pkg::BTD_UNIT_B;
                unit[1] = btd_pkg::BTD_UNIT_B;
                unit[2] = btd_pkg::BTD_UNIT_B;
            end
            4'hC:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_M;
                unit[2] = btd_pkg::BTD_UNIT_B;
            end
            4'hE:
            begin
                unit[0] = btd_pkg::BTD_UNIT_M;
                unit[1] = btd_pkg::BTD_UNIT_F;
                unit[2] = btd_pkg::BTD_UNIT_B;
            end
            default:
            begin
                // 06/07, 14/15, 1A/1B, 1E/1F: no mapping
                reserved = 1'b1;  // [RULE8]
                stop     = 3'b000;
            end
        endcase
    end

    assign long_pair = (unit[1] == btd_pkg::BTD_UNIT_L);  // [RULE12]

    // ------------------------------------------------------------
    // Execution unit per slot
    // ------------------------------------------------------------
    // The L slot takes its unit from the X half, so both halves agree
    genvar g;
    generate
        for (g = 0; g < btd_pkg::NUM_SLOTS; g++)
        begin : g_exec
            btd_slot_exec u_exec
            (
                .i_unit      (unit[g]),
                .i_bits      (slot_bits[g]),
                .i_pair_bits (slot_bits[btd_pkg::NUM_SLOTS-1]),
                .o_exec      (exec_sel[g])
            );  // [RULE6] [RULE13]
        end
    endgenerate

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    btd_pkg::btd_decoded_t next_issue;
    logic                  take;

    assign o_fetch_ready = !o_issue_valid || i_issue_ready;
    assign take          = i_fetch_valid && o_fetch_ready;

    always_comb
    begin
        next_issue            = '0;
        next_issue.addr       = i_fetch_addr;
        next_issue.tmpl       = tmpl;
        next_issue.long_pair  = long_pair;
        next_issue.illegal    = reserved;
        next_issue.misaligned = misaligned;
        // Slot order 0, 1, 2 is kept in the struct fields
        next_issue.slot0 = '{slot_bits[0], unit[0], exec_sel[0], stop[0], !reserved};  // [RULE14] [RULE16]
        next_issue.slot1 = '{slot_bits[1], unit[1], exec_sel[1], stop[1], !reserved};  // [RULE16]
        next_issue.slot2 = '{slot_bits[2], unit[2], exec_sel[2], stop[2], !reserved};  // [RULE10]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            o_issue_valid <= 1'b0;
        else if (o_fetch_ready)
            o_issue_valid <= i_fetch_valid;  // [RULE14]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            o_issue <= '0;
        else if (take)
            o_issue <= next_issue;  // [RULE10]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            o_illegal_op <= 1'b0;
        else
            o_illegal_op <= take && reserved;  // [RULE16]
    end

endmodule // btd_decoder

// file: hw/btd_pkg.sv
// Purpose: Shared types and constants for the bundle template decoder
// Assumes: 128-bit bundles, fetch always little-endian
// Notes:   Template table lives in the decoder body
package btd_pkg;

    // ------------------------------------------------------------
    // Bundle layout
    // ------------------------------------------------------------
    localparam int BUNDLE_W    = 128;
    localparam int SLOT_W      = 41;
    localparam int TMPL_W      = 5;
    localparam int TMPL_LSB    = 0;
    localparam int SLOT0_LSB   = 5;
    localparam int SLOT1_LSB   = 46;
    localparam int SLOT2_LSB   = 87;
    localparam int NUM_SLOTS   = 3;
    localparam int BUNDLE_BYTES = 16;
    localparam int ALIGN_BITS  = 4;
    localparam int ADDR_W      = 64;
    localparam int MAJOR_W     = 4;
    localparam int MAJOR_LSB   = 37;

    // Major opcode of the long branch and long call forms
    localparam logic [3:0] MAJOR_LONG_BRANCH = 4'hC;
    localparam logic [3:0] MAJOR_LONG_CALL   = 4'hD;

    // ------------------------------------------------------------
    // Unit types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BTD_UNIT_NONE = 3'b000,
        BTD_UNIT_M    = 3'b001,
        BTD_UNIT_I    = 3'b010,
        BTD_UNIT_F    = 3'b011,
        BTD_UNIT_B    = 3'b100,
        BTD_UNIT_L    = 3'b101,
        BTD_UNIT_X    = 3'b110
    } btd_unit_t;

    // Where a slot finally executes
    typedef enum logic [1:0] {
        BTD_EXEC_M = 2'b00,
        BTD_EXEC_I = 2'b01,
        BTD_EXEC_F = 2'b10,
        BTD_EXEC_B = 2'b11
    } btd_exec_t;

    typedef struct packed {
        logic [SLOT_W-1:0] bits;
        btd_unit_t         unit;
        btd_exec_t         exec;
        logic              stop_after;
        logic              valid;
    } btd_slot_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [TMPL_W-1:0] tmpl;
        btd_slot_t         slot2;
        btd_slot_t         slot1;
        btd_slot_t         slot0;
        logic              long_pair;
        logic              illegal;
        logic              misaligned;
    } btd_decoded_t;

    localparam logic [TMPL_W-1:0] TMPL_MEMORY_LONG_EXT_A = 5'h04;
    localparam logic [TMPL_W-1:0] TMPL_MEMORY_LONG_EXT_B = 5'h05;

endpackage

// file: hw/btd_slot_exec.sv
// Purpose: Map one slot's unit type to its execution unit
// Assumes: Unit type already taken from the template
// Notes:   Pure combinational; instantiated once per slot
`timescale 1ns/1ns
module btd_slot_exec
(
    // Slot input
    input  wire btd_pkg::btd_unit_t                 i_unit,
    input  wire logic [btd_pkg::SLOT_W-1:0]         i_bits,
    input  wire logic [btd_pkg::SLOT_W-1:0]         i_pair_bits,
    // Result
    output btd_pkg::btd_exec_t                      o_exec
);
    logic [btd_pkg::MAJOR_W-1:0] major;

    // Long pair: major opcode sits in the X half
    assign major = i_pair_bits[btd_pkg::MAJOR_LSB +: btd_pkg::MAJOR_W];

    always_comb
    begin
        case (i_unit)
            btd_pkg::BTD_UNIT_M: o_exec = btd_pkg::BTD_EXEC_M;
            btd_pkg::BTD_UNIT_I: o_exec = btd_pkg::BTD_EXEC_I;
            btd_pkg::BTD_UNIT_F: o_exec = btd_pkg::BTD_EXEC_F;
            btd_pkg::BTD_UNIT_B: o_exec = btd_pkg::BTD_EXEC_B;
            btd_pkg::BTD_UNIT_L, btd_pkg::BTD_UNIT_X:
            begin
                if (major == btd_pkg::MAJOR_LONG_BRANCH ||
                    major == btd_pkg::MAJOR_LONG_CALL)
                    o_exec = btd_pkg::BTD_EXEC_B;  // [RULE13]
                else
                    o_exec = btd_pkg::BTD_EXEC_I;  // [RULE13]
            end
            default: o_exec = btd_pkg::BTD_EXEC_I;
        endcase
    end

    // Unused in exec selection for every slot, long pair included; kept for symmetry of wiring
    logic unused_bits;
    assign unused_bits = ^i_bits;

endmodule // btd_slot_exec

// file: sim/btd_decoder_chk.sv
// Purpose: Port assertions for the bundle decoder
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module btd_decoder_chk
(
    // Clock and reset
    input wire logic                         i_clk_sys,
    input wire logic                         i_reset,
    // Fetch side
    input wire logic                         i_fetch_valid,
    input wire logic [btd_pkg::ADDR_W-1:0]   i_fetch_addr,
    input wire logic [btd_pkg::BUNDLE_W-1:0] i_fetch_bundle,
    input wire logic                         o_fetch_ready,
    // Issue side
    input wire logic                         i_issue_ready,
    input wire logic                         o_issue_valid,
    input wire btd_pkg::btd_decoded_t        o_issue,
    input wire logic                         o_illegal_op
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    wire logic take = i_fetch_valid && o_fetch_ready;
    wire logic rsv  = i_fetch_bundle[4:0] inside {5'h06, 5'h07, 5'h14, 5'h15,
                                                  5'h1A, 5'h1B, 5'h1E, 5'h1F};
    // ----
    // Handshake and field extraction
    // ----
    AST_READY: assert property (o_fetch_ready == (!o_issue_valid || i_issue_ready))
        else $error("fetch ready not tied to issue state");
    AST_TAKE: assert property (take |=> o_issue_valid)
        else $error("taken bundle not issued next cycle");
    AST_HOLD: assert property (o_issue_valid && !i_issue_ready
        |=> o_issue_valid && $stable(o_issue))
        else $error("stalled result changed");
    AST_SLOTS: assert property (take |=>
        o_issue.tmpl == $past(i_fetch_bundle[4:0])
        && o_issue.slot0.bits == $past(i_fetch_bundle[45:5])
        && o_issue.slot1.bits == $past(i_fetch_bundle[86:46])
        && o_issue.slot2.bits == $past(i_fetch_bundle[127:87]))
        else $error("slot or template field misplaced");
    AST_ADDR: assert property (take |=> o_issue.addr == $past(i_fetch_addr)
        && o_issue.misaligned == ($past(i_fetch_addr[3:0]) != 4'h0))
        else $error("address or alignment flag wrong");
    // ----
    // Reserved templates and long pairs
    // ----
    AST_ILL: assert property (take && rsv |=> o_illegal_op && o_issue.illegal
        && !o_issue.slot0.valid && !o_issue.slot1.valid && !o_issue.slot2.valid)
        else $error("reserved template not flagged");
    AST_NOILL: assert property (take && !rsv |=> !o_illegal_op && !o_issue.illegal)
        else $error("defined template flagged illegal");
    AST_PULSE: assert property (o_illegal_op |-> $past(take && rsv))
        else $error("illegal pulse without cause");
    AST_LONG: assert property (o_issue_valid && o_issue.tmpl inside {5'h04, 5'h05}
        |-> o_issue.long_pair && o_issue.slot1.unit == btd_pkg::BTD_UNIT_L
        && o_issue.slot2.unit == btd_pkg::BTD_UNIT_X)
        else $error("long pair not marked");
    AST_LEXEC: assert property (o_issue_valid && o_issue.long_pair
        |-> o_issue.slot1.exec == o_issue.slot2.exec && o_issue.slot2.exec ==
        ((o_issue.slot2.bits[40:37] inside {4'hC, 4'hD})
        ? btd_pkg::BTD_EXEC_B : btd_pkg::BTD_EXEC_I))
        else $error("long pair exec unit wrong");
endmodule // btd_decoder_chk

// file: sim/btd_issue_sink.sv
// Purpose: Issue-stage model taking decoded bundles
// Assumes: Ready may drop at any edge
// Notes:   Slow mode accepts one cycle in three
`timescale 1ns/1ns
module btd_issue_sink
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    // Pace control
    input  wire logic i_slow,
    // Issue handshake
    output logic      o_ready
);
    logic [1:0] phase;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || phase == 2'h2)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end
    // Stops travel with the slots; the sink only paces them
    assign o_ready = !i_slow || (phase == 2'h2);
endmodule // btd_issue_sink

// file: sim/btd_decoder_tb.sv
// Purpose: Self-checking bench for the bundle decoder
// Assumes: Results come back in offered order
// Notes:   Scoreboard queue pairs offers with results
`timescale 1ns/1ns
module btd_decoder_tb;
    logic                  i_clk_sys = 1'b0;
    logic                  i_reset = 1'b1;
    logic                  i_fetch_valid = 1'b0;
    logic [63:0]           i_fetch_addr = 64'h0;
    logic [127:0]          i_fetch_bundle = 128'h0;
    logic                  i_slow = 1'b0;
    logic                  o_fetch_ready, i_issue_ready, o_issue_valid, o_illegal_op;
    btd_pkg::btd_decoded_t o_issue;
    logic [127:0]          qb[$];
    logic [63:0]           qa[$];
    int                    err_total = 0;
    int                    check_count = 0;
    logic                  ill_exp = 1'b0;
    string tab[32] = '{"MII", "MII", "MII", "MII", "ML+", "ML+", "---", "---",
                       "MMI", "MMI", "MMI", "MMI", "MFI", "MFI", "MMF", "MMF",
                       "MIB", "MIB", "MBB", "MBB", "---", "---", "BBB", "BBB",
                       "MMB", "MMB", "---", "---", "MFB", "MFB", "---", "---"};
    always #10 i_clk_sys = ~i_clk_sys;
    btd_decoder dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_fetch_valid(i_fetch_valid), .i_fetch_addr(i_fetch_addr),
        .i_fetch_bundle(i_fetch_bundle), .o_fetch_ready(o_fetch_ready),
        .i_issue_ready(i_issue_ready), .o_issue_valid(o_issue_valid),
        .o_issue(o_issue), .o_illegal_op(o_illegal_op));
    btd_issue_sink sink_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_slow(i_slow), .o_ready(i_issue_ready));
    // ----
    // Expectations and comparison
    // ----
    function automatic logic [2:0] unit_of(input byte c);
        case (c)
            "M": return 3'h1;
            "I": return 3'h2;
            "F": return 3'h3;
            "B": return 3'h4;
            "L": return 3'h5;
            default: return 3'h6;
        endcase
    endfunction
    function automatic logic [1:0] exec_of(input byte c, input logic [3:0] maj);
        case (c)
            "M": return 2'h0;
            "I": return 2'h1;
            "F": return 2'h2;
            "B": return 2'h3;
            default: return (maj inside {4'hC, 4'hD}) ? 2'h3 : 2'h1;
        endcase
    endfunction
    function automatic logic [2:0] stops_of(input logic [4:0] t);
        if (t == 5'h02) return 3'h2;
        if (t == 5'h03) return 3'h6;
        if (t == 5'h0A) return 3'h1;
        if (t == 5'h0B) return 3'h5;
        return t[0] ? 3'h4 : 3'h0;
    endfunction
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic judge();
        logic [127:0]          b;
        logic [63:0]           a;
        string                 s;
        logic                  r;
        btd_pkg::btd_decoded_t d;
        b = qb.pop_front();
        a = qa.pop_front();
        d = o_issue;
        s = tab[b[4:0]];
        r = (s[0] == "-");
        chk("addr", a, d.addr);
        chk("tmpl", b[4:0], d.tmpl);
        chk("s0", b[45:5], d.slot0.bits);
        chk("s1", b[86:46], d.slot1.bits);
        chk("s2", b[127:87], d.slot2.bits);
        chk("mis", a[3:0] != 4'h0, d.misaligned);
        chk("ill", r, d.illegal);
        chk("vld", r ? 3'h0 : 3'h7, {d.slot2.valid, d.slot1.valid, d.slot0.valid});
        chk("stop", r ? 3'h0 : stops_of(b[4:0]),
            {d.slot2.stop_after, d.slot1.stop_after, d.slot0.stop_after});
        if (!r)
        begin
            chk("u0", unit_of(s[0]), d.slot0.unit);
            chk("u1", unit_of(s[1]), d.slot1.unit);
            chk("u2", unit_of(s[2]), d.slot2.unit);
            chk("e0", exec_of(s[0], b[127:124]), d.slot0.exec);
            chk("e1", exec_of(s[1], b[127:124]), d.slot1.exec);
            chk("e2", exec_of(s[2], b[127:124]), d.slot2.exec);
            chk("pair", s[1] == "L", d.long_pair);
        end
    endtask
    always @(posedge i_clk_sys)
    begin
        if (o_issue_valid === 1'b1 && i_issue_ready === 1'b1)
            judge();
    end
    function automatic logic rsv_of(input logic [4:0] t);
        string s;
        s = tab[t];
        return s[0] == "-";
    endfunction
    // Pulse follows a reserved take by exactly one cycle
    always @(posedge i_clk_sys)
    begin
        if (i_reset === 1'b0)
            chk("illop", ill_exp, o_illegal_op);
        ill_exp = i_reset === 1'b0 && i_fetch_valid === 1'b1 && o_fetch_ready === 1'b1
                  && rsv_of(i_fetch_bundle[4:0]);
    end
    // ----
    // Drivers and scenarios
    // ----
    task automatic offer(input logic [127:0] b, input logic [63:0] a, input logic slow);
        #1;
        i_slow = slow;
        i_fetch_valid = 1'b1;
        i_fetch_bundle = b;
        i_fetch_addr = a;
        while (o_fetch_ready !== 1'b1)
            @(posedge i_clk_sys) #1;
        @(posedge i_clk_sys);
        qb.push_back(b);
        qa.push_back(a);
    endtask
    task automatic drain();
        #1;
        i_fetch_valid = 1'b0;
        repeat (300)
            if (qb.size() != 0)
                @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        chk("left", 0, qb.size());
    endtask
    task automatic t_all(input logic slow, input logic [63:0] base);
        for (int k = 0; k < 32; k++)
            offer({41'h1FF_0000_0000 ^ 41'(k), 41'h0AA_5555_5555, 41'h155_AAAA_AAAA,
                   5'(k)}, base + 64'(k * 16), slow);
        drain();
    endtask
    task automatic t_long();
        logic [3:0] m[4] = '{4'hC, 4'hD, 4'h0, 4'h7};
        for (int k = 0; k < 4; k++)
            offer({m[k], 37'h0_1234_5678, 41'h0_F0F0_F0F0, 41'h1_0F0F_0F0F,
                   5'(4 + k % 2)}, 64'h40, 1'b0);
        drain();
    endtask
    // Reset while a flagged result is still pending
    task automatic t_reset();
        offer({123'h0, 5'h06}, 64'h80, 1'b1);
        #1;
        i_fetch_valid = 1'b0;
        i_reset = 1'b1;
        repeat (2)
            @(posedge i_clk_sys);
        #1;
        i_reset = 1'b0;
        chk("rvld", 0, o_issue_valid);
        chk("rill", 0, o_illegal_op);
        chk("rrdy", 1, o_fetch_ready);
        chk("raddr", 0, o_issue.addr);
        qb.delete();
        qa.delete();
        @(posedge i_clk_sys);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        @(posedge i_clk_sys);
        t_all(1'b0, 64'h0);
        t_all(1'b1, 64'h1004);
        t_reset();
        t_long();
        complete_run();
    end
    // Run needs about 150 cycles; this leaves wide margin
    initial
    begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule // btd_decoder_tb
bind btd_decoder btd_decoder_chk chk_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_fetch_valid(i_fetch_valid), .i_fetch_addr(i_fetch_addr),
    .i_fetch_bundle(i_fetch_bundle), .o_fetch_ready(o_fetch_ready),
    .i_issue_ready(i_issue_ready), .o_issue_valid(o_issue_valid),
    .o_issue(o_issue), .o_illegal_op(o_illegal_op));
